// ==== design/ptodr_pkg.sv ====
// ptodr_pkg: constants, register map and types for the power take-off
// disengage / reengage controller.
// assumes a single 10 MHz pclk domain and an APB slave on the register side.
//
// Functional notes
// - every enable is one bit; 0 disables the rule, 1 enables it.
// - engine stop drops engagement when its enable is set.
// - engine speed above drop limit (default 1800, max 5000) drops engagement.
// - leaving neutral drops engagement when its enable is set.
// - releasing the park brake drops engagement when its enable is set.
// - vehicle speed above drop limit (default 0, max 100) drops engagement.
// - after an engine-stop drop, engagement resumes when the engine runs again.
// - after an engine-overspeed drop, resume once engine speed falls below engage limit.
// - after an external-input drop, resume once the input goes inactive.
// - key returning to run permits re-engagement.
// - after a gear-out drop, resume once neutral is selected again.
// - after a park-brake drop, resume once the park brake is reapplied.
// - after a vehicle-overspeed drop, resume once speed falls below engage limit.
// - engine engage limit is programmable, default 1000, range 100 to 5000.
package ptodr_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned SPEED_W = 13;
    localparam int unsigned VSPEED_W = 7;

    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] ENG_DROP_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] ENG_ENGAGE_OFS = 12'h008;
    localparam logic [ADDR_W-1:0] VEH_DROP_OFS = 12'h00c;
    localparam logic [ADDR_W-1:0] VEH_ENGAGE_OFS = 12'h010;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h014;

    // enable bit positions in the control register
    localparam int unsigned B_ENG_STOP_DROP = 0;
    localparam int unsigned B_ENG_OVS_DROP = 1;
    localparam int unsigned B_GEAR_OUT_DROP = 2;
    localparam int unsigned B_HBRK_DROP = 3;
    localparam int unsigned B_VEH_OVS_DROP = 4;
    localparam int unsigned B_EXT_DROP = 5;
    localparam int unsigned B_ENG_RESTART_RES = 8;
    localparam int unsigned B_ENG_SLOW_RES = 9;
    localparam int unsigned B_EXT_RES = 10;
    localparam int unsigned B_IGN_RUN_RES = 11;
    localparam int unsigned B_GEAR_NEUT_RES = 12;
    localparam int unsigned B_HBRK_APPLY_RES = 13;
    localparam int unsigned B_VEH_SLOW_RES = 14;
    localparam int unsigned CTRL_W = 15;

    // engine overspeed drop and engine slowdown resume default on
    localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0202;
    localparam logic [SPEED_W-1:0] ENG_DROP_RST = 13'h0708;
    localparam logic [SPEED_W-1:0] ENG_DROP_MAX = 13'h1388;
    localparam logic [SPEED_W-1:0] ENG_ENGAGE_RST = 13'h03e8;
    localparam logic [SPEED_W-1:0] ENG_ENGAGE_MIN = 13'h0064;
    localparam logic [SPEED_W-1:0] ENG_ENGAGE_MAX = 13'h1388;
    localparam logic [VSPEED_W-1:0] VEH_DROP_RST = 7'h00;
    localparam logic [VSPEED_W-1:0] VEH_DROP_MAX = 7'h64;
    // vehicle engage limit has no printed default in this block's scope
    localparam logic [VSPEED_W-1:0] VEH_ENGAGE_RST = 7'h03;
    localparam logic [VSPEED_W-1:0] VEH_ENGAGE_MAX = 7'h64;

    // status register layout
    localparam int unsigned S_ENGAGED = 0;
    localparam int unsigned S_CAUSE_LSB = 4;
    localparam int unsigned S_LOCKOUT = 8;

    typedef enum logic [2:0] {
        PTODR_CAUSE_NONE,
        PTODR_CAUSE_ENG_STOP,
        PTODR_CAUSE_ENG_OVS,
        PTODR_CAUSE_GEAR_OUT,
        PTODR_CAUSE_HBRK,
        PTODR_CAUSE_VEH_OVS,
        PTODR_CAUSE_EXT,
        PTODR_CAUSE_IGN
    } ptodr_cause_t;

endpackage

// ==== design/ptodr_sync.sv ====
// ptodr_sync: two flip-flop synchroniser for a bundle of level inputs.
// assumes the inputs are slow pins unrelated to pclk.
`timescale 1ns/10ps
module ptodr_sync #(
    parameter int unsigned W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ==== design/ptodr_ctrl.sv ====
// ptodr_ctrl: power take-off disengage / reengage rule engine with APB registers.
// assumes sensor levels and speeds arrive asynchronously on pins; speed bits are
// synchronised on their own, and a word is used only once two samples agree.
`timescale 1ns/10ps
module ptodr_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ptodr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic operator_switch,
    input wire logic engine_running,
    input wire logic [ptodr_pkg::SPEED_W-1:0] engine_speed,
    input wire logic [ptodr_pkg::VSPEED_W-1:0] vehicle_speed,
    input wire logic gear_neutral,
    input wire logic handbrake_set,
    input wire logic ignition_run,
    input wire logic ext_input_active,
    output logic engage_cmd
);
    import ptodr_pkg::*;

    localparam int unsigned NSYNC = 6 + SPEED_W + VSPEED_W;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn_in;
    logic sw_s, run_s, neut_s, hbrk_s, ign_s, ext_s;
    logic [SPEED_W-1:0] espd_s;
    logic [VSPEED_W-1:0] vspd_s;
    logic [SPEED_W-1:0] espd_sync;
    logic [SPEED_W-1:0] espd_prev_reg;
    logic [SPEED_W-1:0] espd_hold_reg;
    logic [VSPEED_W-1:0] vspd_sync;
    logic [VSPEED_W-1:0] vspd_prev_reg;
    logic [VSPEED_W-1:0] vspd_hold_reg;

    assign raw_in = {operator_switch, engine_running, gear_neutral, handbrake_set,
                     ignition_run, ext_input_active, engine_speed, vehicle_speed};
    assign {sw_s, run_s, neut_s, hbrk_s, ign_s, ext_s, espd_sync, vspd_sync} = syn_in;

    ptodr_sync #(
        .W(NSYNC)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(raw_in),
        .q(syn_in)
    );

    // bits of a moving speed may land on different edges; taking a word only
    // after two equal samples keeps a torn value from tripping a limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            espd_prev_reg <= '0;
            vspd_prev_reg <= '0;
        end else begin
            espd_prev_reg <= espd_sync;
            vspd_prev_reg <= vspd_sync;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            espd_hold_reg <= '0;
            vspd_hold_reg <= '0;
        end else begin
            if (espd_sync == espd_prev_reg) begin
                espd_hold_reg <= espd_sync;
            end
            if (vspd_sync == vspd_prev_reg) begin
                vspd_hold_reg <= vspd_sync;
            end
        end
    end

    assign espd_s = espd_hold_reg;
    assign vspd_s = vspd_hold_reg;

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [CTRL_W-1:0] ctrl_reg;
    logic [SPEED_W-1:0] eng_drop_reg;
    logic [SPEED_W-1:0] eng_engage_reg;
    logic [VSPEED_W-1:0] veh_drop_reg;
    logic [VSPEED_W-1:0] veh_engage_reg;
    logic engaged_reg;
    logic lockout_reg;
    ptodr_cause_t cause_reg;
    logic sw_prev_reg;

    logic wr_en;
    logic rd_en;
    logic addr_ok;

    // clamp a written limit into its legal range
    function automatic logic [SPEED_W-1:0] clamp_speed(
        input logic [SPEED_W-1:0] v,
        input logic [SPEED_W-1:0] lo,
        input logic [SPEED_W-1:0] hi
    );
        logic [SPEED_W-1:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    assign addr_ok = (paddr == CTRL_OFS) || (paddr == ENG_DROP_OFS) ||
                     (paddr == ENG_ENGAGE_OFS) || (paddr == VEH_DROP_OFS) ||
                     (paddr == VEH_ENGAGE_OFS) || (paddr == STATUS_OFS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    // zero-wait slave: write acts on the access edge when all lanes are strobed
    assign wr_en = psel && penable && pwrite && addr_ok && (&pstrb);
    assign rd_en = psel && !penable && !pwrite;

    // one bit per enable, written whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_en && paddr == CTRL_OFS) begin
            ctrl_reg <= pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_drop_reg <= ENG_DROP_RST;
            eng_engage_reg <= ENG_ENGAGE_RST;
            veh_drop_reg <= VEH_DROP_RST;
            veh_engage_reg <= VEH_ENGAGE_RST;
        end else if (wr_en) begin
            if (paddr == ENG_DROP_OFS) begin
                eng_drop_reg <= clamp_speed(pwdata[SPEED_W-1:0], '0, ENG_DROP_MAX);
            end
            if (paddr == ENG_ENGAGE_OFS) begin
                eng_engage_reg <= clamp_speed(pwdata[SPEED_W-1:0], ENG_ENGAGE_MIN,
                                              ENG_ENGAGE_MAX);
            end
            if (paddr == VEH_DROP_OFS) begin
                veh_drop_reg <= VSPEED_W'(clamp_speed(SPEED_W'(pwdata[VSPEED_W-1:0]), '0,
                                              SPEED_W'(VEH_DROP_MAX)));
            end
            if (paddr == VEH_ENGAGE_OFS) begin
                veh_engage_reg <= VSPEED_W'(clamp_speed(SPEED_W'(pwdata[VSPEED_W-1:0]),
                                              '0, SPEED_W'(VEH_ENGAGE_MAX)));
            end
        end
    end

    // read data registered in the setup cycle so it is stable in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_en) begin
            case (paddr)
                CTRL_OFS: prdata <= 32'(ctrl_reg);
                ENG_DROP_OFS: prdata <= 32'(eng_drop_reg);
                ENG_ENGAGE_OFS: prdata <= 32'(eng_engage_reg);
                VEH_DROP_OFS: prdata <= 32'(veh_drop_reg);
                VEH_ENGAGE_OFS: prdata <= 32'(veh_engage_reg);
                STATUS_OFS: begin
                    prdata <= (32'(engaged_reg) << S_ENGAGED) |
                              (32'(cause_reg) << S_CAUSE_LSB) |
                              (32'(lockout_reg) << S_LOCKOUT);
                end
                default: prdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // drop and resume conditions

    logic drop_stop, drop_eovs, drop_gear, drop_hbrk, drop_vovs, drop_ext, drop_any;
    logic resume_ok;
    ptodr_cause_t drop_cause;
    logic sw_rise;

    assign drop_stop = ctrl_reg[B_ENG_STOP_DROP] && !run_s;
    assign drop_eovs = ctrl_reg[B_ENG_OVS_DROP] && (espd_s > eng_drop_reg);
    assign drop_gear = ctrl_reg[B_GEAR_OUT_DROP] && !neut_s;
    assign drop_hbrk = ctrl_reg[B_HBRK_DROP] && !hbrk_s;
    assign drop_vovs = ctrl_reg[B_VEH_OVS_DROP] && (vspd_s > veh_drop_reg);
    assign drop_ext = ctrl_reg[B_EXT_DROP] && ext_s;
    // key out of run always drops; only its resume is programmable
    assign drop_any = drop_stop || drop_eovs || drop_gear || drop_hbrk || drop_vovs ||
                      drop_ext || !ign_s;
    assign sw_rise = sw_s && !sw_prev_reg;

    // first matching condition names the cause
    always_comb begin
        drop_cause = PTODR_CAUSE_NONE;
        if (!ign_s) begin
            drop_cause = PTODR_CAUSE_IGN;
        end else if (drop_stop) begin
            drop_cause = PTODR_CAUSE_ENG_STOP;
        end else if (drop_eovs) begin
            drop_cause = PTODR_CAUSE_ENG_OVS;
        end else if (drop_gear) begin
            drop_cause = PTODR_CAUSE_GEAR_OUT;
        end else if (drop_hbrk) begin
            drop_cause = PTODR_CAUSE_HBRK;
        end else if (drop_vovs) begin
            drop_cause = PTODR_CAUSE_VEH_OVS;
        end else if (drop_ext) begin
            drop_cause = PTODR_CAUSE_EXT;
        end
    end

    // resume needs the recorded cause cleared and its own enable
    always_comb begin
        case (cause_reg)
            PTODR_CAUSE_ENG_STOP: resume_ok = ctrl_reg[B_ENG_RESTART_RES] && run_s;
            PTODR_CAUSE_ENG_OVS: begin
                resume_ok = ctrl_reg[B_ENG_SLOW_RES] && (espd_s < eng_engage_reg);
            end
            PTODR_CAUSE_EXT: resume_ok = ctrl_reg[B_EXT_RES] && !ext_s;
            PTODR_CAUSE_IGN: resume_ok = ctrl_reg[B_IGN_RUN_RES] && ign_s;
            PTODR_CAUSE_GEAR_OUT: resume_ok = ctrl_reg[B_GEAR_NEUT_RES] && neut_s;
            PTODR_CAUSE_HBRK: resume_ok = ctrl_reg[B_HBRK_APPLY_RES] && hbrk_s;
            PTODR_CAUSE_VEH_OVS: begin
                resume_ok = ctrl_reg[B_VEH_SLOW_RES] && (vspd_s < veh_engage_reg);
            end
            default: resume_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // engagement state

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_prev_reg <= 1'b0;
        end else begin
            sw_prev_reg <= sw_s;
        end
    end

    // switch off clears everything; drops always beat resumes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            engaged_reg <= 1'b0;
            cause_reg <= PTODR_CAUSE_NONE;
            lockout_reg <= 1'b0;
        end else if (!sw_s) begin
            engaged_reg <= 1'b0;
            cause_reg <= PTODR_CAUSE_NONE;
            lockout_reg <= 1'b0;
        end else if (engaged_reg) begin
            if (drop_any) begin
                engaged_reg <= 1'b0;
                cause_reg <= drop_cause;
            end
        end else if (cause_reg != PTODR_CAUSE_NONE) begin
            if (resume_ok && !drop_any && !lockout_reg) begin
                engaged_reg <= 1'b1;
                cause_reg <= PTODR_CAUSE_NONE;
            end else if (!resume_ok && drop_cause == PTODR_CAUSE_NONE) begin
                // cause cleared but not resumable: wait for a switch cycle
                lockout_reg <= 1'b1;
            end
        end else if (sw_rise && !lockout_reg && !drop_any) begin
            engaged_reg <= 1'b1;
        end
    end

    assign engage_cmd = engaged_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_engaged_then_stop;
        engaged_reg && sw_s && ign_s && ctrl_reg[B_ENG_STOP_DROP] && !run_s;
    endsequence

    chk_stop_drops: assert property (@(posedge pclk) disable iff (!presetn)
        s_engaged_then_stop |=> !engage_cmd && cause_reg == PTODR_CAUSE_ENG_STOP)
        else $error("engine stop did not drop engagement");

    chk_eovs_drops: assert property (@(posedge pclk) disable iff (!presetn)
        engaged_reg && sw_s && ctrl_reg[B_ENG_OVS_DROP] && espd_s > eng_drop_reg
        |=> !engage_cmd)
        else $error("engine overspeed did not drop engagement");

    chk_gear_drops: assert property (@(posedge pclk) disable iff (!presetn)
        engaged_reg && ctrl_reg[B_GEAR_OUT_DROP] && !neut_s |=> !engage_cmd)
        else $error("gear out did not drop engagement");

    chk_hbrk_drops: assert property (@(posedge pclk) disable iff (!presetn)
        engaged_reg && ctrl_reg[B_HBRK_DROP] && !hbrk_s |=> !engage_cmd)
        else $error("handbrake release did not drop engagement");

    chk_vovs_drops: assert property (@(posedge pclk) disable iff (!presetn)
        engaged_reg && ctrl_reg[B_VEH_OVS_DROP] && vspd_s > veh_drop_reg |=> !engage_cmd)
        else $error("vehicle overspeed did not drop engagement");

    chk_restart_resume: assert property (@(posedge pclk) disable iff (!presetn)
        !engaged_reg && sw_s && !lockout_reg && cause_reg == PTODR_CAUSE_ENG_STOP &&
        ctrl_reg[B_ENG_RESTART_RES] && run_s && !drop_any |=> engage_cmd)
        else $error("engine restart did not resume engagement");

    chk_slow_resume: assert property (@(posedge pclk) disable iff (!presetn)
        !engaged_reg && sw_s && !lockout_reg && cause_reg == PTODR_CAUSE_ENG_OVS &&
        ctrl_reg[B_ENG_SLOW_RES] && espd_s < eng_engage_reg && !drop_any |=> engage_cmd)
        else $error("engine slowdown did not resume engagement");

    chk_ext_resume: assert property (@(posedge pclk) disable iff (!presetn)
        !engaged_reg && sw_s && !lockout_reg && cause_reg == PTODR_CAUSE_EXT &&
        ctrl_reg[B_EXT_RES] && !ext_s && !drop_any |=> engage_cmd)
        else $error("external input release did not resume engagement");

    chk_key_resume: assert property (@(posedge pclk) disable iff (!presetn)
        !engaged_reg && sw_s && !lockout_reg && cause_reg == PTODR_CAUSE_IGN &&
        ctrl_reg[B_IGN_RUN_RES] && ign_s && !drop_any |=> engage_cmd)
        else $error("key back in run did not resume engagement");

    chk_neutral_resume: assert property (@(posedge pclk) disable iff (!presetn)
        !engaged_reg && sw_s && !lockout_reg && cause_reg == PTODR_CAUSE_GEAR_OUT &&
        ctrl_reg[B_GEAR_NEUT_RES] && neut_s && !drop_any |=> engage_cmd)
        else $error("neutral did not resume engagement");

    chk_hbrk_resume: assert property (@(posedge pclk) disable iff (!presetn)
        !engaged_reg && sw_s && !lockout_reg && cause_reg == PTODR_CAUSE_HBRK &&
        ctrl_reg[B_HBRK_APPLY_RES] && hbrk_s && !drop_any |=> engage_cmd)
        else $error("handbrake apply did not resume engagement");

    chk_vslow_resume: assert property (@(posedge pclk) disable iff (!presetn)
        !engaged_reg && sw_s && !lockout_reg && cause_reg == PTODR_CAUSE_VEH_OVS &&
        ctrl_reg[B_VEH_SLOW_RES] && vspd_s < veh_engage_reg && !drop_any |=> engage_cmd)
        else $error("vehicle slowdown did not resume engagement");

    chk_switch_off: assert property (@(posedge pclk) disable iff (!presetn)
        !sw_s |=> !engage_cmd && cause_reg == PTODR_CAUSE_NONE)
        else $error("engagement held with switch off");

    chk_lockout_holds: assert property (@(posedge pclk) disable iff (!presetn)
        lockout_reg && sw_s |=> !engage_cmd [*2])
        else $error("engagement returned while locked out");

    chk_limit_range: assert property (@(posedge pclk) disable iff (!presetn)
        eng_engage_reg >= ENG_ENGAGE_MIN && eng_engage_reg <= ENG_ENGAGE_MAX &&
        eng_drop_reg <= ENG_DROP_MAX)
        else $error("speed limit out of range");

endmodule

// ==== sim/ptodr_sensor_model.sv ====
// ptodr_sensor_model: vehicle sensors, key switch and latched cab switch
// assumes the bench calls set_pin from one thread; levels move just after pclk
`timescale 1ns/10ps
module ptodr_sensor_model (
    input wire logic pclk,
    output logic operator_switch,
    output logic engine_running,
    output logic [ptodr_pkg::SPEED_W-1:0] engine_speed,
    output logic [ptodr_pkg::VSPEED_W-1:0] vehicle_speed,
    output logic gear_neutral,
    output logic handbrake_set,
    output logic ignition_run,
    output logic ext_input_active
);
    import ptodr_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // parked truck, engine idling, switch off
    initial begin
        operator_switch = 1'b0;
        engine_running = 1'b1;
        engine_speed = '0;
        vehicle_speed = '0;
        gear_neutral = 1'b1;
        handbrake_set = 1'b1;
        ignition_run = 1'b1;
        ext_input_active = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // two sync flops, two settle edges on speeds, one edge to act: 5 edges
    task automatic set_pin(input int idx, input int val);
        @(posedge pclk);
        case (idx)
            0: engine_running <= val[0];
            1: engine_speed <= val[SPEED_W-1:0];
            2: vehicle_speed <= val[VSPEED_W-1:0];
            3: gear_neutral <= val[0];
            4: handbrake_set <= val[0];
            5: ignition_run <= val[0];
            6: ext_input_active <= val[0];
            default: operator_switch <= val[0];
        endcase
        repeat (5) @(posedge pclk);
    endtask
endmodule

// ==== sim/tb_top.sv ====
// tb_top: self-checking bench for the take-off drop / resume controller
// assumes zero-wait apb slave and at most 5-edge pin-to-output latency
`timescale 1ns/10ps
module tb_top;
    import ptodr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, probe;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, lfsr_state;
    logic [3:0] pstrb;
    logic pready, pslverr, operator_switch, engine_running, gear_neutral;
    logic handbrake_set, ignition_run, ext_input_active, engage_cmd;
    logic [SPEED_W-1:0] engine_speed;
    logic [VSPEED_W-1:0] vehicle_speed;
    logic [32:0] exp_q[$];
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    // per cause: pin, bad level, good level, drop mask, resume bit, cause code
    int t_pin[7] = '{0, 1, 3, 4, 2, 6, 5};
    int t_bad[7] = '{0, 1801, 0, 0, 11, 1, 0};
    int t_good[7] = '{1, 999, 1, 1, 2, 0, 1};
    int t_drop[7] = '{1, 2, 4, 8, 16, 32, 0};
    int t_res[7] = '{8, 9, 12, 13, 14, 10, 11};
    int t_cause[7] = '{1, 2, 3, 4, 5, 6, 7};

    ptodr_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .operator_switch, .engine_running,
        .engine_speed, .vehicle_speed, .gear_neutral, .handbrake_set,
        .ignition_run, .ext_input_active, .engage_cmd);
    ptodr_sensor_model u_veh (.pclk, .operator_switch, .engine_running,
        .engine_speed, .vehicle_speed, .gear_neutral, .handbrake_set,
        .ignition_run, .ext_input_active);
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // apb master; expectation is {pslverr, read data}
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [32:0] exp, input logic [3:0] st = 4'hf);
        exp_q.push_back(exp);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    task automatic probe_eng(input logic e);
        exp_q.push_back({32'h0, e});
        @(posedge pclk);
        probe <= 1'b1;
        @(posedge pclk);
        probe <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // results are matched against the oldest note; writes show only the error bit
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
        end
        if (probe) begin
            check({32'h0, engage_cmd}, exp_q.pop_front());
        end
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        probe = 1'b0;
        lfsr_state = 32'h4516741d;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(CTRL_OFS, 32'h202);
        rd(ENG_DROP_OFS, 32'h708);
        rd(ENG_ENGAGE_OFS, 32'h3e8);
        rd(VEH_DROP_OFS, 32'h0);
        rd(VEH_ENGAGE_OFS, 32'h3);
        rd(STATUS_OFS, 32'h0);
        apb(1'b0, 12'h018, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h020, 32'hffff, {1'b1, 32'h0});
        wr(ENG_DROP_OFS, 32'h1fff);
        rd(ENG_DROP_OFS, 32'h1388);
        apb(1'b1, ENG_DROP_OFS, 32'h708, 33'h0, 4'h3);
        rd(ENG_DROP_OFS, 32'h1388);
        wr(ENG_ENGAGE_OFS, 32'h10);
        rd(ENG_ENGAGE_OFS, 32'h64);
        wr(VEH_DROP_OFS, 32'h7f);
        rd(VEH_DROP_OFS, 32'h64);
        wr(ENG_DROP_OFS, 32'h708);
        wr(ENG_ENGAGE_OFS, 32'h3e8);
        wr(VEH_DROP_OFS, 32'ha);
        // random cruising levels stay below every engage and drop limit
        lfsr_state = lfsr_next(lfsr_state);
        t_good[1] = 200 + int'(lfsr_state % 700);
        lfsr_state = lfsr_next(lfsr_state);
        t_good[4] = int'(lfsr_state % 3);
        u_veh.set_pin(1, t_good[1]);
        u_veh.set_pin(2, t_good[4]);
        u_veh.set_pin(7, 1);
        probe_eng(1'b1);
        for (int i = 0; i < 7; i++) begin
            if (t_drop[i] != 0) begin
                wr(CTRL_OFS, 32'h0);
                u_veh.set_pin(t_pin[i], t_bad[i]);
                probe_eng(1'b1);
                u_veh.set_pin(t_pin[i], t_good[i]);
            end
            wr(CTRL_OFS, 32'(t_drop[i] | (1 << t_res[i])));
            u_veh.set_pin(t_pin[i], t_bad[i]);
            probe_eng(1'b0);
            rd(STATUS_OFS, 32'(t_cause[i] << 4));
            u_veh.set_pin(t_pin[i], t_good[i]);
            probe_eng(1'b1);
            wr(CTRL_OFS, 32'(t_drop[i]));
            u_veh.set_pin(t_pin[i], t_bad[i]);
            probe_eng(1'b0);
            u_veh.set_pin(t_pin[i], t_good[i]);
            probe_eng(1'b0);
            rd(STATUS_OFS, 32'((t_cause[i] << S_CAUSE_LSB) | (1 << S_LOCKOUT)));
            wr(CTRL_OFS, 32'(t_drop[i] | (1 << t_res[i])));
            probe_eng(1'b0);
            u_veh.set_pin(7, 0);
            probe_eng(1'b0);
            u_veh.set_pin(7, 1);
            probe_eng(1'b1);
        end
        rd(STATUS_OFS, 32'h1);
        tally_and_finish();
    end
endmodule
